// ===== hw/serial_port.sv
// synchronous serial port: master/slave shifter with double buffers
`timescale 1ns/1ps
`default_nettype none
`include "serial_port_map.svh"
module serial_port
(
   // clock and reset
   input  wire logic        clk_i,
   input  wire logic        reset_n_i,
   // control bits
   input  wire logic        port_enable_i,
   input  wire logic        master_mode_i,
   input  wire logic        word_width_select_i,
   input  wire logic        clock_idle_polarity_i,
   input  wire logic        clock_edge_select_i,
   input  wire logic        output_pin_disable_i,
   input  wire logic        select_gating_enable_i,
   input  wire logic        framing_enable_i,
   input  wire logic        frame_sync_direction_i,
   input  wire logic [1:0]  primary_prescale_field_i,
   input  wire logic [2:0]  secondary_prescale_field_i,
   input  wire logic        stop_in_idle_bit_i,
   input  wire logic        transfer_done_irq_enable_i,
   // power state
   input  wire logic        cpu_sleep_i,
   input  wire logic        cpu_idle_i,
   // buffer access
   input  wire logic        buffer_write_i,
   input  wire logic [15:0] buffer_wdata_i,
   input  wire logic        buffer_read_i,
   output logic      [15:0] serial_buffer_reg_o,
   // status
   input  wire logic        done_flag_clear_i,
   input  wire logic        overflow_clear_i,
   output logic             transfer_done_flag_o,
   output logic             transfer_irq_o,
   output logic             receive_overflow_flag_o,
   output logic             tx_pending_o,
   output logic             rx_full_o,
   // pins
   input  wire logic        serial_in_pin_i,
   output logic             serial_out_pin_o,
   output logic             serial_out_pin_oe_o,
   input  wire logic        shift_clock_pin_i,
   output logic             shift_clock_pin_o,
   output logic             shift_clock_pin_oe_o,
   input  wire logic        slave_select_pin_n_i,
   output logic             slave_select_pin_o,
   output logic             slave_select_pin_oe_o
);
   typedef struct packed {
      serial_port_pkg::xfer_state_e state;
      serial_port_pkg::word_t       shreg;
      serial_port_pkg::word_t       txbuf;
      serial_port_pkg::word_t       rxbuf;
      logic                         txfull;
      logic                         rxfull;
      logic                         ovf;
      logic                         done;
      logic [`SPM_CNT_W-1:0]        cnt;
      logic                         phase;
      logic                         sck;
      logic                         sout;
      logic                         frame_sync_pulse;
      logic                         width_q;
      logic                         sck_q;
      logic                         ss_q;
   } port_s;
   port_s st_r;
   port_s st_nxt;

   serial_tick_if tk ();
   logic [2:0] pins_s;
   logic       sdi_s;
   logic       sck_s;
   logic       ssn_s;
   logic       halt;
   logic       fr_out;
   logic       fr_in;
   logic       fr_go;
   logic       sel_active;
   logic       ext_lead;
   logic       ext_trail;
   logic       sample_edge;
   logic       drive_edge;
   logic [3:0] msb;
   logic [`SPM_CNT_W-1:0] nbits;
   logic       last_bit;

   serial_sync #(.WIDTH(3)) u_sync
   (
      .clk_i     (clk_i),
      .reset_n_i (reset_n_i),
      .async_i   ({serial_in_pin_i, shift_clock_pin_i,
                   !slave_select_pin_n_i}),
      .sync_o    (pins_s)
   );
   assign sdi_s = pins_s[2];
   assign sck_s = pins_s[1];
   // select goes through inverted so a reset synchroniser reads deselected
   assign ssn_s = !pins_s[0];

   serial_prescaler u_pre
   (
      .clk_i     (clk_i),
      .reset_n_i (reset_n_i),
      .tk        (tk.gen)
   );
   assign tk.primary   = primary_prescale_field_i;
   assign tk.secondary = secondary_prescale_field_i;
   assign tk.run       = master_mode_i && (st_r.state != serial_port_pkg::ST_IDLE);

   // halt when disabled, on sleep, or idle with stop-in-idle set
   assign halt = !port_enable_i || cpu_sleep_i
                 || (cpu_idle_i && stop_in_idle_bit_i);
   assign fr_out = framing_enable_i && !frame_sync_direction_i;
   assign fr_in  = framing_enable_i && frame_sync_direction_i;
   assign sel_active = !select_gating_enable_i || framing_enable_i
                       || !ssn_s;
   // framed input: start only once the received sync pulse has ended
   assign fr_go = !fr_in || (st_r.ss_q && !ssn_s);
   assign msb   = word_width_select_i ? `SPM_MSB_WORD : `SPM_MSB_BYTE;
   assign nbits = word_width_select_i ? `SPM_BITS_WORD
                                      : `SPM_BITS_BYTE;
   assign last_bit = (st_r.cnt == nbits - 5'h01);

   // polarity-adjusted external clock edges: lead = idle-to-active
   assign ext_lead  = (sck_s ^ clock_idle_polarity_i)
                      && !(st_r.sck_q ^ clock_idle_polarity_i);
   assign ext_trail = !(sck_s ^ clock_idle_polarity_i)
                      && (st_r.sck_q ^ clock_idle_polarity_i);
   // edge select set: data changes active-to-idle, sampled idle-to-active
   always_comb
   begin
      sample_edge = 1'b0;
      drive_edge  = 1'b0;
      if (master_mode_i)
      begin
         sample_edge = tk.tick && !st_r.phase;
         drive_edge  = tk.tick && st_r.phase;
      end
      else if (clock_edge_select_i)
      begin
         sample_edge = ext_lead;
         drive_edge  = ext_trail;
      end
      else
      begin
         sample_edge = ext_trail;
         drive_edge  = ext_lead;
      end
   end

   always_comb
   begin
      st_nxt = st_r;
      st_nxt.sck_q   = sck_s;
      st_nxt.ss_q    = ssn_s;
      st_nxt.width_q = word_width_select_i;
      // software read empties the receive buffer and unblocks overflow
      if (buffer_read_i)
      begin
         st_nxt.rxfull = 1'b0;
         st_nxt.ovf    = 1'b0;
      end
      if (overflow_clear_i)
      begin
         st_nxt.ovf = 1'b0;
      end
      if (done_flag_clear_i)
      begin
         st_nxt.done = 1'b0;
      end
      if (buffer_write_i)
      begin
         st_nxt.txbuf  = buffer_wdata_i;
         st_nxt.txfull = 1'b1;
      end
      st_nxt.frame_sync_pulse = 1'b0;
      case (st_r.state)
         serial_port_pkg::ST_IDLE:
         begin
            st_nxt.sck = clock_idle_polarity_i;
            st_nxt.cnt = 5'h00;
            st_nxt.phase = 1'b0;
            if (st_r.txfull && !halt && !st_r.ovf && master_mode_i
                && fr_go)
            begin
               // master starts as soon as data waits
               st_nxt.shreg  = st_r.txbuf;
               st_nxt.txfull = buffer_write_i;
               st_nxt.sout   = st_r.txbuf[msb];
               st_nxt.state  = fr_out ? serial_port_pkg::ST_SYNC
                                      : serial_port_pkg::ST_SHIFT;
               st_nxt.frame_sync_pulse  = fr_out;
            end
            else if (!master_mode_i && !halt && !st_r.ovf && sel_active
                     && fr_go)
            begin
               // slave loads pending data, else keeps shreg contents
               if (st_r.txfull)
               begin
                  st_nxt.shreg  = st_r.txbuf;
                  st_nxt.txfull = buffer_write_i;
               end
               st_nxt.sout  = st_r.txfull ? st_r.txbuf[msb]
                                          : st_r.shreg[msb];
               st_nxt.state = serial_port_pkg::ST_SHIFT;
            end
         end
         serial_port_pkg::ST_SYNC:
         begin
            // sync pulse spans one full shift clock period
            st_nxt.frame_sync_pulse = 1'b1;
            if (tk.tick)
            begin
               st_nxt.phase = !st_r.phase;
               st_nxt.sck = !st_r.sck;
               if (st_r.phase)
               begin
                  st_nxt.frame_sync_pulse = 1'b0;
                  st_nxt.state = serial_port_pkg::ST_SHIFT;
               end
            end
         end
         serial_port_pkg::ST_SHIFT:
         begin
            if (master_mode_i && tk.tick)
            begin
               st_nxt.phase = !st_r.phase;
               st_nxt.sck = !st_r.sck;
            end
            if (sample_edge)
            begin
               // shift in at bit 0 while msb leaves on the out pin
               st_nxt.shreg = {st_r.shreg[14:0], sdi_s};
               if (last_bit)
               begin
                  st_nxt.done = 1'b1;
                  if (st_r.rxfull)
                  begin
                     st_nxt.ovf = 1'b1;
                  end
                  else
                  begin
                     st_nxt.rxbuf  = {st_r.shreg[14:0], sdi_s};
                     st_nxt.rxfull = 1'b1;
                  end
                  st_nxt.state = master_mode_i ? serial_port_pkg::ST_HOLD
                                               : serial_port_pkg::ST_IDLE;
               end
               else
               begin
                  st_nxt.cnt = st_r.cnt + 5'h01;
               end
            end
            if (drive_edge && st_r.cnt != 5'h00)
            begin
               st_nxt.sout = st_r.shreg[msb];
            end
         end
         serial_port_pkg::ST_HOLD:
         begin
            // finish the last half clock back to idle level
            if (tk.tick)
            begin
               st_nxt.sck   = clock_idle_polarity_i;
               st_nxt.state = serial_port_pkg::ST_IDLE;
            end
         end
         default:
         begin
            st_nxt.state = serial_port_pkg::ST_IDLE;
         end
      endcase
      // overflow blocks further clocking until the buffer is read or the overflow is cleared
      if (st_r.ovf && st_r.state == serial_port_pkg::ST_SHIFT)
      begin
         st_nxt.state = serial_port_pkg::ST_IDLE;
      end
      // select high, width change or halt aborts the word
      if (halt || (st_r.width_q != word_width_select_i)
          || (!master_mode_i && select_gating_enable_i
              && !framing_enable_i && ssn_s))
      begin
         st_nxt.state = serial_port_pkg::ST_IDLE;
         st_nxt.cnt   = 5'h00;
         st_nxt.phase = 1'b0;
         st_nxt.sck   = clock_idle_polarity_i;
      end
   end

   always_ff @(posedge clk_i)
   begin
      if (!reset_n_i)
      begin
         st_r <= '{state: serial_port_pkg::ST_IDLE, sck_q: 1'b0,
                   ss_q: 1'b1, default: '0};
      end
      else
      begin
         st_r <= st_nxt;
      end
   end

   assign serial_buffer_reg_o     = st_r.rxbuf;
   assign transfer_done_flag_o    = st_r.done;
   assign transfer_irq_o          = st_r.done
                                    && transfer_done_irq_enable_i;
   assign receive_overflow_flag_o = st_r.ovf;
   assign tx_pending_o            = st_r.txfull;
   assign rx_full_o               = st_r.rxfull;
   assign serial_out_pin_o        = st_r.sout;
   // output released when disabled or deselected
   assign serial_out_pin_oe_o = port_enable_i && !output_pin_disable_i
                                && !(select_gating_enable_i && !master_mode_i
                                     && !framing_enable_i
                                     && ssn_s);
   assign shift_clock_pin_o    = st_r.sck;
   assign shift_clock_pin_oe_o = port_enable_i && master_mode_i;
   assign slave_select_pin_o    = st_r.frame_sync_pulse;
   assign slave_select_pin_oe_o = port_enable_i && fr_out;
endmodule
`default_nettype wire

// ===== hw/serial_port_map.svh
// constants for the synchronous serial port: widths, bit counts, msb indices, reset word
`ifndef SERIAL_PORT_MAP_SVH
`define SERIAL_PORT_MAP_SVH
`define SPM_WORD_W        16
`define SPM_CNT_W         5
`define SPM_BITS_BYTE     5'h08
`define SPM_BITS_WORD     5'h10
`define SPM_MSB_BYTE      4'h7
`define SPM_MSB_WORD      4'hf
`define SPM_DIV_W         8
`define SPM_RESET_WORD    16'h0000
`endif

// ===== hw/serial_port_pkg.sv
// types shared by the serial port modules
package serial_port_pkg;
   typedef enum logic [3:0] {
      ST_IDLE  = 4'b0001,
      ST_SYNC  = 4'b0010,
      ST_SHIFT = 4'b0100,
      ST_HOLD  = 4'b1000
   } xfer_state_e;
   typedef logic [15:0] word_t;
endpackage

// ===== hw/serial_prescaler.sv
// two-stage divider making a half-period tick for the master shift clock
`timescale 1ns/1ps
`default_nettype none
`include "serial_port_map.svh"
module serial_prescaler
(
   // clock and reset
   input  wire logic      clk_i,
   input  wire logic      reset_n_i,
   // tick carrier
   serial_tick_if.gen     tk
);
   typedef struct packed {
      logic [`SPM_DIV_W-1:0] cnt;
      logic                  tick;
   } pre_s;
   pre_s st_r;
   pre_s st_nxt;
   logic [`SPM_DIV_W-1:0] ratio;

   // primary 1/4/16 with secondary 1..8, primary code 3 fixed at 255; product less one is terminal count
   always_comb
   begin
      ratio = 8'h00;
      case (tk.primary)
         2'h0: ratio = {5'h00, tk.secondary} + 8'h01;
         2'h1: ratio = {3'h0, tk.secondary, 2'h0} + 8'h04;
         2'h2: ratio = {1'h0, tk.secondary, 4'h0} + 8'h10;
         default: ratio = 8'hff;
      endcase
      st_nxt = st_r;
      st_nxt.tick = 1'b0;
      if (!tk.run)
      begin
         st_nxt.cnt = 8'h00;
      end
      else if (st_r.cnt >= ratio - 8'h01)
      begin
         st_nxt.cnt = 8'h00;
         st_nxt.tick = 1'b1;
      end
      else
      begin
         st_nxt.cnt = st_r.cnt + 8'h01;
      end
   end

   always_ff @(posedge clk_i)
   begin
      if (!reset_n_i)
      begin
         st_r <= '0;
      end
      else
      begin
         st_r <= st_nxt;
      end
   end

   assign tk.tick = st_r.tick;
endmodule
`default_nettype wire

// ===== hw/serial_sync.sv
// two-flop synchronisers for the port's input pins
`timescale 1ns/1ps
`default_nettype none
module serial_sync
#(
   parameter int WIDTH = 3
)
(
   // clock and reset
   input  wire logic             clk_i,
   input  wire logic             reset_n_i,
   // raw and synchronised levels
   input  wire logic [WIDTH-1:0] async_i,
   output logic      [WIDTH-1:0] sync_o
);
   typedef struct packed {
      logic [WIDTH-1:0] meta;
      logic [WIDTH-1:0] sync;
   } sync_s;
   sync_s st_r;
   sync_s st_nxt;

   always_comb
   begin
      st_nxt.meta = async_i;
      st_nxt.sync = st_r.meta;
   end

   always_ff @(posedge clk_i)
   begin
      if (!reset_n_i)
      begin
         st_r <= '0;
      end
      else
      begin
         st_r <= st_nxt;
      end
   end

   assign sync_o = st_r.sync;
endmodule
`default_nettype wire

// ===== hw/serial_tick_if.sv
// carrier of the master clock tick between prescaler and core
`timescale 1ns/1ps
`default_nettype none
interface serial_tick_if;
   logic       run;
   logic       tick;
   logic [1:0] primary;
   logic [2:0] secondary;
   modport gen  (input run, input primary, input secondary, output tick);
   modport core (output run, output primary, output secondary, input tick);
endinterface
`default_nettype wire

// ===== testbench/serial_peer_model.sv
// far-end serial device: samples on rising clock, drives on falling
`timescale 1ns/1ps
`default_nettype none
module serial_peer_model
(
   // serial lines
   input  wire logic        sck_i,
   input  wire logic        mosi_i,
   output logic             miso_o,
   // control and data
   input  wire logic        reset_n_i,
   input  wire logic        wide_i,
   input  wire logic [15:0] tx_i,
   output logic      [15:0] rx_o
);
   logic [3:0] cnt_r;
   logic [3:0] idx_r;
   logic [3:0] last;
   assign last = wide_i ? 4'hf : 4'h7;
   // clock is an input here, owned by the master
   always @(posedge sck_i or negedge reset_n_i)
   begin
      if (!reset_n_i)
         cnt_r <= 4'h0;
      else
         cnt_r <= (cnt_r == last) ? 4'h0 : cnt_r + 4'h1;
   end
   always @(posedge sck_i)
      rx_o <= {rx_o[14:0], mosi_i};
   // change on the trailing edge so the bit is settled at the next lead
   always @(negedge sck_i or negedge reset_n_i)
   begin
      if (!reset_n_i)
         idx_r <= 4'h0;
      else
         idx_r <= cnt_r;
   end
   assign miso_o = tx_i[last - idx_r];
endmodule
`default_nettype wire

// ===== testbench/serial_port_assertions.sv
// concurrent checks on the serial port's pins and flags
`timescale 1ns/1ps
`default_nettype none
module serial_port_assertions
(
   // clock and reset
   input wire logic        clk_i,
   input wire logic        reset_n_i,
   // controls
   input wire logic        master_mode_i,
   input wire logic        clock_idle_polarity_i,
   input wire logic        output_pin_disable_i,
   input wire logic        select_gating_enable_i,
   input wire logic        framing_enable_i,
   input wire logic        frame_sync_direction_i,
   input wire logic        transfer_done_irq_enable_i,
   input wire logic        cpu_sleep_i,
   input wire logic        buffer_read_i,
   input wire logic        slave_select_pin_n_i,
   // outputs
   input wire logic [15:0] serial_buffer_reg_o,
   input wire logic        transfer_done_flag_o,
   input wire logic        transfer_irq_o,
   input wire logic        receive_overflow_flag_o,
   input wire logic        rx_full_o,
   input wire logic        serial_out_pin_oe_o,
   input wire logic        shift_clock_pin_o,
   input wire logic        shift_clock_pin_oe_o,
   input wire logic        slave_select_pin_oe_o
);
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!reset_n_i);
   a_sck_dir: assert property (!master_mode_i |-> !shift_clock_pin_oe_o)
      else $error("shift clock driven in slave mode");
   // four cycles covers the input synchroniser on the select pin
   a_sel_off: assert property (
      (!master_mode_i && select_gating_enable_i && !framing_enable_i &&
      slave_select_pin_n_i)[*4] |-> !serial_out_pin_oe_o)
      else $error("output driven while deselected");
   a_out_off: assert property (
      output_pin_disable_i |-> !serial_out_pin_oe_o)
      else $error("output driven while disabled");
   a_irq_gate: assert property (transfer_irq_o ==
      (transfer_done_flag_o && transfer_done_irq_enable_i))
      else $error("irq does not follow flag and enable");
   a_done_full: assert property (
      $rose(transfer_done_flag_o) |-> rx_full_o)
      else $error("done without received word");
   a_ovf_drop: assert property ($rose(receive_overflow_flag_o) |->
      $stable(serial_buffer_reg_o)) else $error("overflow word stored");
   a_read_clears: assert property (buffer_read_i |=>
      !rx_full_o && !receive_overflow_flag_o) else $error("read kept flags");
   a_done_mid: assert property (master_mode_i &&
      $rose(transfer_done_flag_o) |-> shift_clock_pin_o !=
      clock_idle_polarity_i) else $error("done not inside last bit");
   a_frame_dir: assert property (framing_enable_i |->
      slave_select_pin_oe_o == !frame_sync_direction_i)
      else $error("sync pin direction wrong");
   a_sleep_halt: assert property (cpu_sleep_i[*3] |->
      $stable(shift_clock_pin_o) && !$rose(transfer_done_flag_o))
      else $error("activity during sleep");
   c_done: cover property ($rose(transfer_done_flag_o));
   c_ovf: cover property ($rose(receive_overflow_flag_o));
   c_sleep: cover property (cpu_sleep_i[*3]);
endmodule
bind serial_port serial_port_assertions chk_u
(
   .clk_i(clk_i), .reset_n_i(reset_n_i), .master_mode_i(master_mode_i),
   .clock_idle_polarity_i(clock_idle_polarity_i),
   .output_pin_disable_i(output_pin_disable_i),
   .select_gating_enable_i(select_gating_enable_i),
   .framing_enable_i(framing_enable_i),
   .frame_sync_direction_i(frame_sync_direction_i),
   .transfer_done_irq_enable_i(transfer_done_irq_enable_i),
   .cpu_sleep_i(cpu_sleep_i), .buffer_read_i(buffer_read_i),
   .slave_select_pin_n_i(slave_select_pin_n_i),
   .serial_buffer_reg_o(serial_buffer_reg_o),
   .transfer_done_flag_o(transfer_done_flag_o),
   .transfer_irq_o(transfer_irq_o),
   .receive_overflow_flag_o(receive_overflow_flag_o), .rx_full_o(rx_full_o),
   .serial_out_pin_oe_o(serial_out_pin_oe_o),
   .shift_clock_pin_o(shift_clock_pin_o),
   .shift_clock_pin_oe_o(shift_clock_pin_oe_o),
   .slave_select_pin_oe_o(slave_select_pin_oe_o)
);
`default_nettype wire

// ===== testbench/spi_master_slave_port_tb_top.sv
// self-checking bench for the serial port, master and slave sides against a peer
`timescale 1ns/1ps
`default_nettype none
module spi_master_slave_port_tb_top;
   logic        clk_i = 1'b0, reset_n_i = 1'b0, peer_rst_n = 1'b1;
   logic        port_enable_i = 1'b1, master_mode_i = 1'b1;
   logic        word_width_select_i = 1'b0, clock_idle_polarity_i = 1'b0;
   logic        clock_edge_select_i = 1'b0, output_pin_disable_i = 1'b0;
   logic        select_gating_enable_i = 1'b0, framing_enable_i = 1'b0;
   logic        frame_sync_direction_i = 1'b0, stop_in_idle_bit_i = 1'b0;
   logic        transfer_done_irq_enable_i = 1'b0, cpu_sleep_i = 1'b0;
   logic        cpu_idle_i = 1'b0, buffer_write_i = 1'b0;
   logic        buffer_read_i = 1'b0, done_flag_clear_i = 1'b0;
   logic        overflow_clear_i = 1'b0, slave_select_pin_n_i = 1'b1;
   logic [1:0]  primary_prescale_field_i = 2'h1;
   logic [2:0]  secondary_prescale_field_i = 3'h1;
   logic [15:0] buffer_wdata_i = 16'h0000, peer_tx = 16'h0000;
   logic [15:0] serial_buffer_reg_o, peer_rx;
   logic        transfer_done_flag_o, transfer_irq_o, receive_overflow_flag_o;
   logic        tx_pending_o, rx_full_o, serial_out_pin_o, serial_out_pin_oe_o;
   logic        shift_clock_pin_o, shift_clock_pin_oe_o, slave_select_pin_o;
   logic        slave_select_pin_oe_o, miso, sck_w, ext_sck = 1'b0;
   int          errors = 0, n_checks = 0, n;
   always #10 clk_i = ~clk_i;
   // bench plays the far master whenever the port does not drive the clock
   assign sck_w = shift_clock_pin_oe_o ? shift_clock_pin_o : ext_sck;
   serial_port dut
   (
      .clk_i(clk_i), .reset_n_i(reset_n_i), .port_enable_i(port_enable_i),
      .master_mode_i(master_mode_i), .word_width_select_i(word_width_select_i),
      .clock_idle_polarity_i(clock_idle_polarity_i),
      .clock_edge_select_i(clock_edge_select_i),
      .output_pin_disable_i(output_pin_disable_i),
      .select_gating_enable_i(select_gating_enable_i),
      .framing_enable_i(framing_enable_i),
      .frame_sync_direction_i(frame_sync_direction_i),
      .primary_prescale_field_i(primary_prescale_field_i),
      .secondary_prescale_field_i(secondary_prescale_field_i),
      .stop_in_idle_bit_i(stop_in_idle_bit_i),
      .transfer_done_irq_enable_i(transfer_done_irq_enable_i),
      .cpu_sleep_i(cpu_sleep_i), .cpu_idle_i(cpu_idle_i),
      .buffer_write_i(buffer_write_i), .buffer_wdata_i(buffer_wdata_i),
      .buffer_read_i(buffer_read_i), .serial_buffer_reg_o(serial_buffer_reg_o),
      .done_flag_clear_i(done_flag_clear_i),
      .overflow_clear_i(overflow_clear_i),
      .transfer_done_flag_o(transfer_done_flag_o),
      .transfer_irq_o(transfer_irq_o),
      .receive_overflow_flag_o(receive_overflow_flag_o),
      .tx_pending_o(tx_pending_o), .rx_full_o(rx_full_o),
      .serial_in_pin_i(miso), .serial_out_pin_o(serial_out_pin_o),
      .serial_out_pin_oe_o(serial_out_pin_oe_o), .shift_clock_pin_i(sck_w),
      .shift_clock_pin_o(shift_clock_pin_o),
      .shift_clock_pin_oe_o(shift_clock_pin_oe_o),
      .slave_select_pin_n_i(slave_select_pin_n_i),
      .slave_select_pin_o(slave_select_pin_o),
      .slave_select_pin_oe_o(slave_select_pin_oe_o)
   );
   serial_peer_model peer
   (
      .sck_i(sck_w), .mosi_i(serial_out_pin_o), .miso_o(miso),
      .reset_n_i(peer_rst_n), .wide_i(word_width_select_i), .tx_i(peer_tx),
      .rx_o(peer_rx)
   );
   task automatic chk(input logic [15:0] seen, exp, input string name);
      n_checks++;
      if (seen !== exp)
      begin
         errors++;
         $display("unexpected %s expected %h seen %h", name, exp, seen);
      end
   endtask
   task automatic complete_run;
      if (errors == 0 && n_checks > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask
   task automatic cyc(input int k);
      repeat (k) @(negedge clk_i);
   endtask
   task automatic wr(input logic [15:0] d);
      buffer_wdata_i = d;
      buffer_write_i = 1'b1;
      cyc(1);
      buffer_write_i = 1'b0;
   endtask
   // clears the done flag, and reads the buffer when rd is set
   task automatic pulse(input logic rd);
      done_flag_clear_i = 1'b1;
      buffer_read_i = rd;
      cyc(1);
      done_flag_clear_i = 1'b0;
      buffer_read_i = 1'b0;
   endtask
   task automatic wait_hi(input logic ovf, output int k);
      k = 0;
      while ((ovf ? receive_overflow_flag_o : transfer_done_flag_o) !== 1'b1)
      begin
         k++;
         if (k > 3000)
         begin
            chk(16'h0000, 16'h0001, "completion wait");
            complete_run();
         end
         cyc(1);
      end
   endtask
   initial
   begin
      cyc(1);
      peer_rst_n = 1'b0;
      cyc(1);
      reset_n_i = 1'b1;
      cyc(2);
      chk(serial_buffer_reg_o, 16'h0000, "rx buffer");
      chk({11'h0, transfer_done_flag_o, transfer_irq_o,
         receive_overflow_flag_o, tx_pending_o, rx_full_o}, 16'h0000, "flags");
      clock_idle_polarity_i = 1'b1;
      cyc(3);
      chk(16'(shift_clock_pin_o), 16'h0001, "idle clock");
      clock_idle_polarity_i = 1'b0;
      cyc(3);
      peer_rst_n = 1'b1;
      peer_tx = 16'h003c;
      wr(16'h00a5);
      wait_hi(1'b0, n);
      // half period 4*2 clocks, 8 bits of two halves each
      chk(16'(n >= 120 && n <= 140), 16'h0001, "duration");
      cyc(20);
      chk({8'h00, peer_rx[7:0]}, 16'h00a5, "peer rx");
      chk({8'h00, serial_buffer_reg_o[7:0]}, 16'h003c, "rx");
      chk(16'(rx_full_o), 16'h0001, "rx full");
      chk(16'(transfer_irq_o), 16'h0000, "masked irq");
      transfer_done_irq_enable_i = 1'b1;
      cyc(1);
      chk(16'(transfer_irq_o), 16'h0001, "irq");
      pulse(1'b0);
      peer_tx = 16'h0077;
      wr(16'h0011);
      wait_hi(1'b1, n);
      cyc(20);
      chk({8'h00, serial_buffer_reg_o[7:0]}, 16'h003c, "kept rx");
      pulse(1'b1);
      chk({rx_full_o, receive_overflow_flag_o}, 16'h0000, "read");
      // width only changes while the port is off
      port_enable_i = 1'b0;
      cyc(1);
      word_width_select_i = 1'b1;
      cyc(1);
      port_enable_i = 1'b1;
      peer_tx = 16'h5a0f;
      wr(16'hc3a5);
      cyc(4);
      wr(16'h9e61);
      chk(16'(tx_pending_o), 16'h0001, "tx pending");
      wait_hi(1'b0, n);
      cyc(1);
      chk(peer_rx, 16'hc3a5, "peer rx16");
      chk(serial_buffer_reg_o, 16'h5a0f, "rx16");
      pulse(1'b1);
      wait_hi(1'b0, n);
      cyc(1);
      chk(peer_rx, 16'h9e61, "queued word");
      chk(16'(tx_pending_o), 16'h0000, "tx drained");
      pulse(1'b1);
      master_mode_i = 1'b0;
      select_gating_enable_i = 1'b1;
      cyc(6);
      chk(16'(shift_clock_pin_oe_o), 16'h0000, "slave clock");
      chk(16'(serial_out_pin_oe_o), 16'h0000, "deselected");
      clock_edge_select_i = 1'b1;
      peer_tx = 16'h36c9;
      wr(16'h4b17);
      slave_select_pin_n_i = 1'b0;
      cyc(4);
      // bench as master: rising edge samples, falling edge shifts
      repeat (16)
      begin
         ext_sck = 1'b1;
         cyc(8);
         ext_sck = 1'b0;
         cyc(8);
      end
      slave_select_pin_n_i = 1'b1;
      cyc(4);
      chk(peer_rx, 16'h4b17, "slave tx");
      chk(serial_buffer_reg_o, 16'h36c9, "slave rx");
      chk(16'(transfer_done_flag_o), 16'h0001, "slave done");
      pulse(1'b1);
      framing_enable_i = 1'b1;
      cyc(1);
      chk(16'(slave_select_pin_oe_o), 16'h0001, "sync out");
      frame_sync_direction_i = 1'b1;
      cyc(1);
      chk(16'(slave_select_pin_oe_o), 16'h0000, "sync in");
      framing_enable_i = 1'b0;
      frame_sync_direction_i = 1'b0;
      select_gating_enable_i = 1'b0;
      master_mode_i = 1'b1;
      output_pin_disable_i = 1'b1;
      cyc(2);
      chk(16'(serial_out_pin_oe_o), 16'h0000, "out disabled");
      output_pin_disable_i = 1'b0;
      stop_in_idle_bit_i = 1'b1;
      cpu_idle_i = 1'b1;
      wr(16'h0055);
      cyc(300);
      chk(16'(transfer_done_flag_o), 16'h0000, "idle stop");
      cpu_idle_i = 1'b0;
      cpu_sleep_i = 1'b1;
      cyc(300);
      chk(16'(transfer_done_flag_o), 16'h0000, "sleep");
      chk(16'(tx_pending_o), 16'h0001, "kept in sleep");
      cpu_sleep_i = 1'b0;
      wait_hi(1'b0, n);
      cyc(1);
      chk(peer_rx, 16'h0055, "after sleep");
      complete_run();
   end
endmodule
`default_nettype wire
